// File: verilog/tec_timer_consts.vh
`ifndef TEC_TIMER_CONSTS_VH
`define TEC_TIMER_CONSTS_VH

// address map, byte addresses on the apb bus
`define TEC_CH_STRIDE 8'h10
`define TEC_OFS_CTRL 4'h0
`define TEC_OFS_LOW 4'h4
`define TEC_OFS_HIGH 4'h8
`define TEC_ADDR_INTC 8'h30

// control register fields
`define TEC_MODE_MSB 7
`define TEC_MODE_LSB 6
`define TEC_RUN_BIT 4
`define TEC_POL_BIT 3
`define TEC_CTRL_MASK 8'hD8

// mode field encodings
`define TEC_MODE_OFF 2'h0
`define TEC_MODE_EVENT 2'h1
`define TEC_MODE_TIMER 2'h2
`define TEC_MODE_PULSE 2'h3

// interrupt control register fields
`define TEC_INTC_EN_LSB 0
`define TEC_INTC_REQ_LSB 4

// reset values and the counter full value
`define TEC_CTRL_RST 8'h00
`define TEC_CNT_RST 16'h0000
`define TEC_BYTE_RST 8'h00
`define TEC_CNT_FULL 16'hFFFF

// timing
`define TEC_SYSCLK_HZ 200000000
`define TEC_T0_DIV 4
`define TEC_T1_HZ 32768
`define TEC_T1_DIV (`TEC_SYSCLK_HZ / `TEC_T1_HZ)

`endif

// File: verilog/tec_timer.v
// Behaviour
// R1 - mode chosen by control bits seven and six
// R2 - run bit gates counting
// R3 - polarity bit selects active pin edge
// R4 - mode one-zero selects interval timer
// R5 - timer mode counts each internal tick
// R6 - overflow requests interrupt, reloads, keeps counting
// R7 - interrupt suppressed when enable bit zero
// R8 - event mode counts pin edges undivided
// R9 - event edge rising for zero, falling for one
// R10 - event counting continues in power-down, wakes
// R11 - mode one-one selects pulse width measurement
// R12 - timer and pulse modes use internal clock
// R13 - pulse mode run only arms counter
// R14 - polarity zero: count falling until rising
// R15 - polarity one: count rising until falling
// R16 - pulse end clears run bit
// R17 - other modes never clear run bit
// R18 - after pulse, ignore pin, hold count
// R19 - pulse mode driven by transitions, not level
// R20 - software sets mode before run bit
// R21 - mode zero-one selects event counting
// R22 - third timer supports interval timer only
// R23 - timer0 sysclk/4, timer1 32768Hz tick
// R24 - preload write loads counter when stopped
// R25 - low byte buffered, high read latches low
//
// register map, byte addresses on the apb bus:
//    timer n control at n*0x10 + 0x0
//    timer n low byte at n*0x10 + 0x4
//    timer n high byte at n*0x10 + 0x8
//    interrupt control at 0x30
// control byte: mode in bits 7:6, run in bit 4, polarity in bit 3
//    mode 00 holds the counter still
//    mode 01 counts pin edges
//    mode 10 counts internal ticks
//    mode 11 measures one pulse on the pin
// interrupt control: enables in bits 2:0, request flags in bits 6:4
//    a request flag is cleared by writing one to it
//    an overflow in the same cycle keeps the flag set
//
// handshake: every transfer takes exactly one wait state
//    setup, first access cycle with ready low, second with ready high
//    read data and slave error stand only while ready is high
//    unmapped addresses answer with slave error and zero data
//
// limitations a user must know:
//    the counter is not inhibited during a bus access, so a read of the
//    high byte may race a carry out of the low byte; the high read latches
//    the low byte at the same edge, so the pair is always coherent
//    timer2 has no pin and runs as an interval timer whatever its mode bits
//    internal ticks stop in power-down, so only an event counter can wake
//    pin edges are seen one clock after the pin moves
//    a measured pulse shorter than one tick may read zero
//
// trade-off: the low byte latch costs one byte per timer but lets
// software read a running counter without stopping it
`timescale 1ns/1ps
`include "tec_timer_consts.vh"

module tec_timer #(
   parameter T0_DIV = `TEC_T0_DIV,
   parameter T1_DIV = `TEC_T1_DIV
) (
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // timer pins and power state
   input wire i_cnt0_input_pin,
   input wire i_cnt1_input_pin,
   input wire i_pdown,
   // requests
   output wire [2:0] o_irq,
   output wire o_wake
);

   // divider end points, cut to the counter width on purpose
   localparam integer T0_LAST_I = T0_DIV - 1;
   localparam integer T1_LAST_I = T1_DIV - 1;
   localparam [15:0] T0_LAST = T0_LAST_I[15:0];
   localparam [15:0] T1_LAST = T1_LAST_I[15:0];

   reg [7:0] ctrl_ff [0:2];
   reg [15:0] cnt_ff [0:2];
   reg [15:0] pre_ff [0:2];
   reg [7:0] lowbuf_ff [0:2];
   reg [7:0] rdlat_ff [0:2];
   reg [2:0] meas_ff;
   reg [2:0] pin_d_ff;
   reg [2:0] req_ff;
   reg [2:0] ien_ff;
   reg [2:0] irq_ff;
   reg wake_ff;
   reg [15:0] div0_ff;
   reg [15:0] div1_ff;
   reg tick0_ff;
   reg tick1_ff;
   reg pready_ff;
   reg pslverr_ff;
   reg [31:0] prdata_ff;

   reg [2:0] inc_c;
   reg [2:0] start_c;
   reg [2:0] done_c;
   reg [2:0] ovf_c;
   reg [2:0] wr_ctrl_c;
   reg [2:0] wr_low_c;
   reg [2:0] wr_high_c;
   reg [2:0] rd_high_c;
   reg wr_intc_c;
   reg hit_c;
   reg [31:0] rd_val_c;
   reg [1:0] md;
   integer i;

   wire [2:0] pin_now = {1'b0, i_cnt1_input_pin, i_cnt0_input_pin};
   wire [2:0] rise = pin_now & ~pin_d_ff;
   wire [2:0] fall = ~pin_now & pin_d_ff;
   // internal clocks stop in power-down; only the pin keeps an event counter alive
   wire [2:0] itick = {~i_pdown, tick1_ff & ~i_pdown, tick0_ff & ~i_pdown}; // R12 R10
   wire access = i_psel & i_penable;
   wire xfer = access & pready_ff;
   wire [1:0] ch = i_paddr[5:4];
   wire [3:0] ofs = i_paddr[3:0];

   function [1:0] eff_mode;
      input [7:0] ctrl;
      input integer chan;
      begin
         if (chan == 2)
            eff_mode = `TEC_MODE_TIMER; // R22
         else
            eff_mode = ctrl[`TEC_MODE_MSB:`TEC_MODE_LSB]; // R1
      end
   endfunction

   function sel_edge;
      input pol;
      input r;
      input f;
      begin
         sel_edge = pol ? f : r; // R3
      end
   endfunction

   // counting decisions per channel
   always @*
   begin
      inc_c = 3'h0;
      start_c = 3'h0;
      done_c = 3'h0;
      ovf_c = 3'h0;
      md = `TEC_MODE_OFF;
      for (i = 0; i < 3; i = i + 1)
      begin
         md = eff_mode(ctrl_ff[i], i);
         if (ctrl_ff[i][`TEC_RUN_BIT]) // R2
         begin
            case (md)
               `TEC_MODE_TIMER: // R4
                  inc_c[i] = itick[i]; // R5
               `TEC_MODE_EVENT: // R21
                  inc_c[i] = sel_edge(ctrl_ff[i][`TEC_POL_BIT], rise[i], fall[i]); // R8 R9 R10
               `TEC_MODE_PULSE: // R11
               begin
                  // armed until the leading edge, then counting until the trailing edge
                  start_c[i] = ~meas_ff[i] & sel_edge(~ctrl_ff[i][`TEC_POL_BIT], rise[i], fall[i]); // R13 R14 R15 R19
                  done_c[i] = meas_ff[i] & sel_edge(ctrl_ff[i][`TEC_POL_BIT], rise[i], fall[i]); // R14 R15 R19
                  inc_c[i] = meas_ff[i] & ~done_c[i] & itick[i];
               end
               default:
                  inc_c[i] = 1'b0;
            endcase
         end
         ovf_c[i] = inc_c[i] & (cnt_ff[i] == `TEC_CNT_FULL); // R6
      end
   end

   // apb decode
   always @*
   begin
      wr_ctrl_c = 3'h0;
      wr_low_c = 3'h0;
      wr_high_c = 3'h0;
      rd_high_c = 3'h0;
      wr_intc_c = 1'b0;
      hit_c = 1'b0;
      rd_val_c = 32'h00000000;
      if (i_paddr == `TEC_ADDR_INTC)
      begin
         hit_c = 1'b1;
         wr_intc_c = i_pwrite;
         rd_val_c[`TEC_INTC_EN_LSB +: 3] = ien_ff;
         rd_val_c[`TEC_INTC_REQ_LSB +: 3] = req_ff;
      end
      else if (i_paddr[7:6] == 2'h0 && ch != 2'h3)
      begin
         case (ofs)
            `TEC_OFS_CTRL:
            begin
               hit_c = 1'b1;
               wr_ctrl_c[ch] = i_pwrite;
               rd_val_c[7:0] = ctrl_ff[ch];
            end
            `TEC_OFS_LOW:
            begin
               hit_c = 1'b1;
               wr_low_c[ch] = i_pwrite;
               rd_val_c[7:0] = rdlat_ff[ch]; // R25
            end
            `TEC_OFS_HIGH:
            begin
               hit_c = 1'b1;
               wr_high_c[ch] = i_pwrite;
               rd_high_c[ch] = ~i_pwrite;
               rd_val_c[7:0] = cnt_ff[ch][15:8];
            end
            default:
               hit_c = 1'b0;
         endcase
      end
   end

   // internal tick dividers
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         div0_ff <= 16'h0000;
         div1_ff <= 16'h0000;
         tick0_ff <= 1'b0;
         tick1_ff <= 1'b0;
      end
      else
      begin
         tick0_ff <= (div0_ff == T0_LAST); // R23
         div0_ff <= (div0_ff == T0_LAST) ? 16'h0000 : div0_ff + 16'h0001;
         tick1_ff <= (div1_ff == T1_LAST); // R23
         div1_ff <= (div1_ff == T1_LAST) ? 16'h0000 : div1_ff + 16'h0001;
      end
   end

   // apb handshake: one wait state, read data sampled on the first access edge
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end
      else
      begin
         pready_ff <= access & ~pready_ff;
         if (access & ~pready_ff)
         begin
            pslverr_ff <= ~hit_c;
            prdata_ff <= i_pwrite ? 32'h00000000 : rd_val_c;
         end
         else
         begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
         end
      end
   end

   // counters, control and request flags
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            ctrl_ff[i] <= `TEC_CTRL_RST;
            cnt_ff[i] <= `TEC_CNT_RST;
            pre_ff[i] <= `TEC_CNT_RST;
            lowbuf_ff[i] <= `TEC_BYTE_RST;
            rdlat_ff[i] <= `TEC_BYTE_RST;
         end
         meas_ff <= 3'h0;
         pin_d_ff <= 3'h0;
         req_ff <= 3'h0;
         ien_ff <= 3'h0;
         irq_ff <= 3'h0;
         wake_ff <= 1'b0;
      end
      else
      begin
         pin_d_ff <= pin_now;
         for (i = 0; i < 3; i = i + 1)
         begin
            if (inc_c[i])
               cnt_ff[i] <= ovf_c[i] ? pre_ff[i] : cnt_ff[i] + 16'h0001; // R6
            if (start_c[i])
               meas_ff[i] <= 1'b1;
            if (done_c[i])
            begin
               // only the pulse mode ever drops the run bit by itself
               ctrl_ff[i][`TEC_RUN_BIT] <= 1'b0; // R16 R17 R18
               meas_ff[i] <= 1'b0;
            end
            // high read latches the low byte in the same edge the high byte is sampled
            if (access & ~pready_ff & rd_high_c[i])
               rdlat_ff[i] <= cnt_ff[i][7:0]; // R25
            if (xfer & wr_low_c[i])
               lowbuf_ff[i] <= i_pwdata[7:0]; // R25
            if (xfer & wr_high_c[i])
            begin
               pre_ff[i] <= {i_pwdata[7:0], lowbuf_ff[i]}; // R25
               if (~ctrl_ff[i][`TEC_RUN_BIT])
                  cnt_ff[i] <= {i_pwdata[7:0], lowbuf_ff[i]}; // R24
            end
            // a software write wins over the hardware clear and re-arms the measurement
            if (xfer & wr_ctrl_c[i])
            begin
               ctrl_ff[i] <= i_pwdata[7:0] & `TEC_CTRL_MASK; // R2 R20
               meas_ff[i] <= 1'b0;
            end
         end
         // set wins over a clear by writing one
         if (xfer & wr_intc_c)
         begin
            req_ff <= (req_ff & ~i_pwdata[`TEC_INTC_REQ_LSB +: 3]) | ovf_c; // R6
            ien_ff <= i_pwdata[`TEC_INTC_EN_LSB +: 3];
         end
         else
            req_ff <= req_ff | ovf_c; // R6
         irq_ff <= req_ff & ien_ff; // R7
         wake_ff <= i_pdown & (|ovf_c); // R10
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_irq = irq_ff;
   assign o_wake = wake_ff;

endmodule

// File: test/tec_timer_checker.sv
`timescale 1ns/1ps
`include "tec_timer_consts.vh"
module tec_timer_checker (
   // clock, reset, apb
   input wire i_clk,
   input wire i_rst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   // power state and requests
   input wire i_pdown,
   input wire [2:0] o_irq,
   input wire o_wake
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire map_ok = (i_paddr == `TEC_ADDR_INTC) || (i_paddr < 8'h2C && i_paddr[1:0] == 2'h0 && i_paddr[3:2] != 2'h3);
   wire done = i_psel && i_penable && o_pready;
   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   sequence answer_s;
      !o_pready ##1 o_pready;
   endsequence
   wait_state_a: assert property (setup_s |=> answer_s) else $error("answer not after one wait");
   pready_one_a: assert property (o_pready |=> !o_pready) else $error("ready too long");
   idle_data_a: assert property (!o_pready |-> o_prdata == 32'h0) else $error("data outside answer");
   unmapped_err_a: assert property (done |-> o_pslverr == !map_ok) else $error("slave error wrong");
   rsv_bits_a: assert property (done && !i_pwrite && map_ok && i_paddr < 8'h30 && i_paddr[3:0] == `TEC_OFS_CTRL
      |-> (o_prdata & ~32'hD8) == 32'h0) else $error("reserved bits set");
   wake_cause_a: assert property (o_wake |-> $past(i_pdown)) else $error("wake while awake");
   wake_pulse_a: assert property (o_wake |=> !o_wake) else $error("wake too long");
   irq_clear_a: assert property (|($past(o_irq) & ~o_irq) |-> $past(done && i_pwrite, 2))
      else $error("irq dropped without write");
endmodule

// File: test/tec_pin_src.sv
`timescale 1ns/1ps
module tec_pin_src (
   // clock
   input wire i_clk,
   // timer pins
   output reg [1:0] o_pin
);
   initial o_pin = 2'h0;
   // pins move right after an edge, like logic clocked by i_clk
   task automatic tog(input int ch, input int n, input int w);
      repeat (n)
      begin
         repeat (w) @(posedge i_clk);
         o_pin[ch] <= ~o_pin[ch];
      end
   endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
   reg i_clk, i_rst, i_psel, i_penable, i_pwrite, i_pdown;
   reg [7:0] i_paddr;
   reg [31:0] i_pwdata, r;
   wire [31:0] o_prdata;
   wire o_pready, o_pslverr, o_wake;
   wire [2:0] o_irq;
   wire [1:0] pin;
   integer miscompares = 0, n_compared = 0, wakes = 0;
   tec_timer #(.T0_DIV(2), .T1_DIV(8)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_cnt0_input_pin(pin[0]),
      .i_cnt1_input_pin(pin[1]), .i_pdown(i_pdown), .o_irq(o_irq), .o_wake(o_wake));
   tec_pin_src src (.i_clk(i_clk), .o_pin(pin));
   initial
   begin
      i_clk = 0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(negedge i_clk) if (o_wake === 1'b1) wakes = wakes + 1;
   task give_verdict;
      begin
         $display("compared %0d mismatches %0d", n_compared, miscompares);
         if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e)
         begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   // one idle cycle after each transfer keeps every strobe to one change per edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         k = 0;
         i_psel <= 1'b1;
         i_pwrite <= w;
         i_paddr <= a;
         i_pwdata <= d;
         @(posedge i_clk);
         i_penable <= 1'b1;
         // sample ready with the request still standing; read data is taken at that same edge
         @(posedge i_clk);
         while (o_pready !== 1'b1 && k < 20)
         begin
            k = k + 1;
            @(posedge i_clk);
         end
         r = o_prdata;
         if (k >= 20)
         begin
            miscompares = miscompares + 1;
            give_verdict;
         end
         i_psel <= 1'b0;
         i_penable <= 1'b0;
         @(posedge i_clk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(r, e);
      end
   endtask
   initial
   begin
      i_rst = 1;
      i_psel = 0;
      i_penable = 0;
      i_pwrite = 0;
      i_paddr = 0;
      i_pwdata = 0;
      i_pdown = 0;
      repeat (10) @(posedge i_clk);
      i_rst <= 0;
      @(posedge i_clk);
      rd(8'h00, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h0C, 32'h0);
      wr(8'h00, 32'hFF);
      rd(8'h00, 32'hD8);
      wr(8'h00, 32'h0);
      $display("reset and map test done");
      wr(8'h04, 32'h34);
      wr(8'h08, 32'h12);
      wr(8'h04, 32'h77);
      rd(8'h08, 32'h12);
      rd(8'h04, 32'h34);
      $display("byte access test done");
      wr(8'h24, 32'h0);
      wr(8'h28, 32'h0);
      wr(8'h20, 32'h80);
      wr(8'h20, 32'h90);
      wr(8'h20, 32'h80);
      rd(8'h28, 32'h0);
      rd(8'h24, 32'h4);
      wr(8'h30, 32'h4);
      wr(8'h24, 32'hFE);
      wr(8'h28, 32'hFF);
      wr(8'h20, 32'h90);
      wr(8'h20, 32'h80);
      rd(8'h30, 32'h44);
      @(negedge i_clk);
      chk(o_irq, 32'h4);
      rd(8'h28, 32'hFF);
      rd(8'h24, 32'hFE);
      wr(8'h30, 32'h44);
      rd(8'h30, 32'h4);
      $display("interval timer test done");
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h40);
      wr(8'h00, 32'h50);
      src.tog(0, 5, 3);
      rd(8'h00, 32'h50);
      wr(8'h00, 32'h40);
      rd(8'h08, 32'h0);
      rd(8'h04, 32'h3);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h48);
      wr(8'h00, 32'h58);
      src.tog(0, 3, 3);
      wr(8'h00, 32'h48);
      rd(8'h08, 32'h0);
      rd(8'h04, 32'h2);
      wr(8'h14, 32'hFF);
      wr(8'h18, 32'hFF);
      wr(8'h10, 32'h40);
      wr(8'h10, 32'h50);
      i_pdown <= 1'b1;
      src.tog(1, 1, 2);
      repeat (4) @(posedge i_clk);
      i_pdown <= 1'b0;
      chk(wakes, 32'h1);
      chk(o_irq, 32'h0);
      rd(8'h30, 32'h24);
      $display("event counter test done");
      wr(8'h08, 32'h0);
      wr(8'h00, 32'hC8);
      src.tog(0, 1, 2);
      wr(8'h00, 32'hD8);
      src.tog(0, 1, 30);
      src.tog(0, 2, 20);
      src.tog(0, 4, 3);
      rd(8'h00, 32'hC8);
      rd(8'h08, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(r >= 9 && r <= 11, 32'h1);
      $display("pulse width test done");
      give_verdict;
   end
endmodule
bind tec_timer tec_timer_checker chk_i (.*);
